//--- core/sov_map.svh
`ifndef SOV_MAP_SVH
`define SOV_MAP_SVH
// Register offsets
`define SOV_ADDR_RST_SRC 8'h11
`define SOV_ADDR_RST_CTL 8'h12
`define SOV_ADDR_FLG_SRC 8'h13
`define SOV_ADDR_FLG_CTL 8'h14
`define SOV_ADDR_WD_CFG  8'h15
`define SOV_ADDR_STATUS  8'h17
// Reset values
`define SOV_RST_SRC_INIT 8'h01
`define SOV_RST_CTL_INIT 8'h00
`define SOV_FLG_SRC_INIT 8'h01
`define SOV_FLG_CTL_INIT 8'h00
`define SOV_WD_CFG_INIT  8'h00
// Readable bits of the control registers
`define SOV_RST_CTL_MASK 8'h8F
`define SOV_FLG_CTL_MASK 8'h0F
// Field positions
`define SOV_SRC_MR     0
`define SOV_SRC_PEER   1
`define SOV_SRC_IN_LO  2
`define SOV_SRC_IN_HI  7
`define SOV_CTL_MODE   0
`define SOV_CTL_DLY_LO 1
`define SOV_CTL_DLY_HI 3
`define SOV_CTL_WD_DEP 7
`define SOV_WD_MODE    0
`define SOV_WD_INI_LO  1
`define SOV_WD_INI_HI  3
`define SOV_WD_NRM_LO  4
`define SOV_WD_NRM_HI  6
`define SOV_WD_EN      7
// Timing: clock, time base tick and watchdog pulse
`define SOV_CLK_NS      20
`define SOV_TICK_US     5
`define SOV_TICK_CYC    ((`SOV_TICK_US * 1000) / `SOV_CLK_NS)
`define SOV_WD_PULSE_NS 100
`define SOV_WD_PULSE_CYC (`SOV_WD_PULSE_NS / `SOV_CLK_NS)
// Release delays in microseconds, codes 0 to 7
`define SOV_T_R0_US 25
`define SOV_T_R1_US 1560
`define SOV_T_R2_US 6250
`define SOV_T_R3_US 25000
`define SOV_T_R4_US 50000
`define SOV_T_R5_US 200000
`define SOV_T_R6_US 400000
`define SOV_T_R7_US 1600000
// Watchdog periods in microseconds, codes 0 to 7
`define SOV_T_W0_US 6250
`define SOV_T_W1_US 25000
`define SOV_T_W2_US 100000
`define SOV_T_W3_US 400000
`define SOV_T_W4_US 1600000
`define SOV_T_W5_US 6400
`define SOV_T_W6_US 25600000
`define SOV_T_W7_US 102400000
`endif

//--- core/sov_pkg.sv
package sov_pkg;
  // Watchdog sequencing states
  typedef enum logic [3:0] {
    SOV_WD_OFF    = 4'b0001,
    SOV_WD_FIRST  = 4'b0010,
    SOV_WD_STEADY = 4'b0100,
    SOV_WD_FIRED  = 4'b1000
  } sov_wd_e;
  // Tick counts up to the longest watchdog period
  typedef logic [24:0] sov_cnt_t;
endpackage : sov_pkg

//--- core/sov_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sov_map.svh"
module sov_top
  import sov_pkg::*;
#(
  parameter int TICK_CYC = `SOV_TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cfg_wr,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       manual_reset_in_b,
  input  wire logic [5:0] monitored_supply_prim_ok,
  input  wire logic [5:0] monitored_supply_sec_ok,
  input  wire logic       watchdog_kick_in,
  output logic            reset_out_b,
  output logic            voltage_fault_flag_out_b,
  output logic            watchdog_expiry_out_b,
  output logic            reset_open_drain,
  output logic            flag_open_drain,
  output logic            wd_open_drain
);
  logic [7:0] rst_src, rst_ctl, flg_src, flg_ctl, wd_cfg, rdata;
  logic [7:0] next_rst_src, next_rst_ctl, next_flg_src, next_flg_ctl;
  logic [7:0] next_wd_cfg, next_rdata;
  logic [11:0] tick_cnt, next_tick_cnt;
  logic        tick;
  logic [1:0]  out_b, next_out_b, fault;
  sov_cnt_t    cnt [0:1];
  sov_cnt_t    next_cnt [0:1];
  sov_cnt_t    dly [0:1];
  sov_wd_e     wd_state, next_wd_state;
  sov_cnt_t    wd_cnt, next_wd_cnt, first_ticks, steady_ticks;
  logic        wd_b, next_wd_b, kick_q, next_kick_q, kick_edge;
  logic [3:0]  pulse_cnt, next_pulse_cnt;

  // Release delay lookup; flag code 110 reuses the reset figure
  function automatic sov_cnt_t rel_ticks(input logic [2:0] code);
    case (code)
      3'h0:    rel_ticks = 25'(`SOV_T_R0_US / `SOV_TICK_US);
      3'h1:    rel_ticks = 25'(`SOV_T_R1_US / `SOV_TICK_US);
      3'h2:    rel_ticks = 25'(`SOV_T_R2_US / `SOV_TICK_US);
      3'h3:    rel_ticks = 25'(`SOV_T_R3_US / `SOV_TICK_US);
      3'h4:    rel_ticks = 25'(`SOV_T_R4_US / `SOV_TICK_US);
      3'h5:    rel_ticks = 25'(`SOV_T_R5_US / `SOV_TICK_US);
      3'h6:    rel_ticks = 25'(`SOV_T_R6_US / `SOV_TICK_US);
      default: rel_ticks = 25'(`SOV_T_R7_US / `SOV_TICK_US);
    endcase
  endfunction : rel_ticks

  // Watchdog period lookup, shared by both period fields
  function automatic sov_cnt_t wd_ticks(input logic [2:0] code);
    case (code)
      3'h0:    wd_ticks = 25'(`SOV_T_W0_US / `SOV_TICK_US);
      3'h1:    wd_ticks = 25'(`SOV_T_W1_US / `SOV_TICK_US);
      3'h2:    wd_ticks = 25'(`SOV_T_W2_US / `SOV_TICK_US);
      3'h3:    wd_ticks = 25'(`SOV_T_W3_US / `SOV_TICK_US);
      3'h4:    wd_ticks = 25'(`SOV_T_W4_US / `SOV_TICK_US);
      3'h5:    wd_ticks = 25'(`SOV_T_W5_US / `SOV_TICK_US);
      3'h6:    wd_ticks = 25'(`SOV_T_W6_US / `SOV_TICK_US);
      default: wd_ticks = 25'(`SOV_T_W7_US / `SOV_TICK_US);
    endcase
  endfunction : wd_ticks

  // Register writes take effect at once; read data is registered
  always_comb begin
    next_rst_src = rst_src;
    next_rst_ctl = rst_ctl;
    next_flg_src = flg_src;
    next_flg_ctl = flg_ctl;
    next_wd_cfg  = wd_cfg;
    if (cfg_wr) begin
      case (cfg_addr)
        `SOV_ADDR_RST_SRC: next_rst_src = cfg_wdata;
        `SOV_ADDR_RST_CTL: next_rst_ctl = cfg_wdata & `SOV_RST_CTL_MASK;
        `SOV_ADDR_FLG_SRC: next_flg_src = cfg_wdata;
        `SOV_ADDR_FLG_CTL: next_flg_ctl = cfg_wdata & `SOV_FLG_CTL_MASK;
        `SOV_ADDR_WD_CFG:  next_wd_cfg  = cfg_wdata;
        default:           next_wd_cfg  = wd_cfg;
      endcase
    end
    case (cfg_addr)
      `SOV_ADDR_RST_SRC: next_rdata = rst_src;
      `SOV_ADDR_RST_CTL: next_rdata = rst_ctl;
      `SOV_ADDR_FLG_SRC: next_rdata = flg_src;
      `SOV_ADDR_FLG_CTL: next_rdata = flg_ctl;
      `SOV_ADDR_WD_CFG:  next_rdata = wd_cfg;
      `SOV_ADDR_STATUS:  next_rdata = {wd_state, 1'b0, wd_b, out_b[1], out_b[0]};
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_src <= `SOV_RST_SRC_INIT;
      rst_ctl <= `SOV_RST_CTL_INIT;
      flg_src <= `SOV_FLG_SRC_INIT;
      flg_ctl <= `SOV_FLG_CTL_INIT;
      wd_cfg  <= `SOV_WD_CFG_INIT;
      rdata   <= 8'h00;
    end else begin
      rst_src <= next_rst_src;
      rst_ctl <= next_rst_ctl;
      flg_src <= next_flg_src;
      flg_ctl <= next_flg_ctl;
      wd_cfg  <= next_wd_cfg;
      rdata   <= next_rdata;
    end
  end

  // Shared time base; a long period takes fewer counter bits than
  // clock-counted delays
  always_comb begin
    tick = (tick_cnt == 12'h000);
    next_tick_cnt = tick ? 12'(TICK_CYC - 1) : tick_cnt - 12'h001;
  end

  // Assertion causes for both outputs
  always_comb begin
    // reset causes; watchdog cause; registered flag fed in
    fault[0] = (rst_src[`SOV_SRC_MR] & ~manual_reset_in_b)
             | (rst_src[`SOV_SRC_PEER] & ~out_b[1])
             | (|(rst_src[`SOV_SRC_IN_HI:`SOV_SRC_IN_LO] & ~monitored_supply_prim_ok))
             | (rst_ctl[`SOV_CTL_WD_DEP] & ~wd_b)
             | (rst_src == 8'h00 && !rst_ctl[`SOV_CTL_WD_DEP]);
    // flag causes; registered reset fed in
    fault[1] = (flg_src[`SOV_SRC_MR] & ~manual_reset_in_b)
             | (flg_src[`SOV_SRC_PEER] & ~out_b[0])
             | (|(flg_src[`SOV_SRC_IN_HI:`SOV_SRC_IN_LO] & ~monitored_supply_sec_ok))
             | (flg_src == 8'h00);
    // reset delay code; flag delay code
    dly[0] = rel_ticks(rst_ctl[`SOV_CTL_DLY_HI:`SOV_CTL_DLY_LO]);
    dly[1] = rel_ticks(flg_ctl[`SOV_CTL_DLY_HI:`SOV_CTL_DLY_LO]);
  end

  // Output channels; one extra tick covers the partial first tick
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_out_b[i] = out_b[i];
      next_cnt[i]   = cnt[i];
      if (fault[i]) begin
        next_out_b[i] = 1'b0;
        next_cnt[i]   = dly[i] + 25'd1;
      // release once all causes clear and delay done
      end else if (!out_b[i]) begin
        if (cnt[i] == 25'd0) begin
          next_out_b[i] = 1'b1;
        end else if (tick) begin
          next_cnt[i] = cnt[i] - 25'd1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= 12'h000;
      out_b    <= 2'b00;
      cnt[0]   <= 25'(`SOV_T_R0_US / `SOV_TICK_US + 1);
      cnt[1]   <= 25'(`SOV_T_R0_US / `SOV_TICK_US + 1);
    end else begin
      tick_cnt <= next_tick_cnt;
      out_b    <= next_out_b;
      cnt[0]   <= next_cnt[0];
      cnt[1]   <= next_cnt[1];
    end
  end

  // Watchdog sequencing
  always_comb begin
    first_ticks    = wd_ticks(wd_cfg[`SOV_WD_INI_HI:`SOV_WD_INI_LO]);
    steady_ticks   = wd_ticks(wd_cfg[`SOV_WD_NRM_HI:`SOV_WD_NRM_LO]);
    kick_edge      = watchdog_kick_in ^ kick_q;
    next_kick_q    = watchdog_kick_in;
    next_wd_state  = wd_state;
    next_wd_cnt    = wd_cnt;
    next_wd_b      = wd_b;
    next_pulse_cnt = pulse_cnt;
    if (!wd_cfg[`SOV_WD_EN]) begin
      next_wd_state = SOV_WD_OFF;
      next_wd_b     = 1'b1;
    end else begin
      case (wd_state)
        SOV_WD_OFF: begin
          next_wd_state = SOV_WD_FIRST;
          next_wd_cnt   = first_ticks;
        end
        SOV_WD_FIRST: begin
          if (!out_b[0]) begin
            next_wd_cnt = first_ticks;
          end else if (kick_edge || wd_cnt == 25'd0) begin
            next_wd_state = SOV_WD_STEADY;
            next_wd_cnt   = steady_ticks;
          end else if (tick) begin
            next_wd_cnt = wd_cnt - 25'd1;
          end
        end
        SOV_WD_STEADY: begin
          if (!out_b[0]) begin
            next_wd_state = SOV_WD_FIRST;
            next_wd_cnt   = first_ticks;
          end else if (kick_edge) begin
            next_wd_cnt = steady_ticks;
          end else if (wd_cnt == 25'd0) begin
            next_wd_state  = SOV_WD_FIRED;
            next_wd_b      = 1'b0;
            next_pulse_cnt = 4'(`SOV_WD_PULSE_CYC - 1);
          end else if (tick) begin
            next_wd_cnt = wd_cnt - 25'd1;
          end
        end
        SOV_WD_FIRED: begin
          // short pulse when reset is linked
          if (rst_ctl[`SOV_CTL_WD_DEP]) begin
            if (pulse_cnt == 4'h0) begin
              next_wd_b     = 1'b1;
              next_wd_state = SOV_WD_FIRST;
              next_wd_cnt   = first_ticks;
            end else begin
              next_pulse_cnt = pulse_cnt - 4'h1;
            end
          end else if (kick_edge) begin
            next_wd_b     = 1'b1;
            next_wd_state = SOV_WD_FIRST;
            next_wd_cnt   = first_ticks;
          end
        end
        default: begin
          next_wd_state = SOV_WD_OFF;
          next_wd_b     = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wd_state  <= SOV_WD_OFF;
      wd_cnt    <= 25'd0;
      wd_b      <= 1'b1;
      kick_q    <= 1'b0;
      pulse_cnt <= 4'h0;
    end else begin
      wd_state  <= next_wd_state;
      wd_cnt    <= next_wd_cnt;
      wd_b      <= next_wd_b;
      kick_q    <= next_kick_q;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // Pins come straight from flops; driver modes
  assign cfg_rdata                = rdata;
  assign reset_out_b              = out_b[0];
  assign voltage_fault_flag_out_b = out_b[1];
  assign watchdog_expiry_out_b    = wd_b;
  assign reset_open_drain         = rst_ctl[`SOV_CTL_MODE];
  assign flag_open_drain          = flg_ctl[`SOV_CTL_MODE];
  assign wd_open_drain            = wd_cfg[`SOV_WD_MODE];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rst_mr_cause_a: assert property (
    rst_src[0] && !manual_reset_in_b |=> !reset_out_b)
    else $error("reset not asserted by manual reset");
  rst_wd_cause_a: assert property (
    rst_ctl[7] && !watchdog_expiry_out_b |=> !reset_out_b)
    else $error("reset not asserted by watchdog");
  rst_release_a: assert property (
    $rose(reset_out_b) |-> $past(cnt[0]) == 25'd0 && !$past(fault[0]))
    else $error("reset released before delay ended");
  flg_sec_cause_a: assert property (
    flg_src[2] && !monitored_supply_sec_ok[0] |=> !voltage_fault_flag_out_b)
    else $error("flag not asserted by secondary detector");
  flg_hold_a: assert property (
    !voltage_fault_flag_out_b && cnt[1] != 25'd0 |=> !voltage_fault_flag_out_b)
    else $error("flag released early");
  no_source_a: assert property (
    flg_src == 8'h00 |=> !voltage_fault_flag_out_b)
    else $error("flag with no source released");
  wd_off_a: assert property (
    !wd_cfg[7] |=> watchdog_expiry_out_b && wd_state == SOV_WD_OFF)
    else $error("disabled watchdog active");
  wd_pulse_a: assert property (
    $fell(watchdog_expiry_out_b) && rst_ctl[7] && $stable(rst_ctl) && wd_cfg[7]
    |-> !watchdog_expiry_out_b[*5] ##1 watchdog_expiry_out_b)
    else $error("watchdog pulse length wrong");
  wd_hold_a: assert property (
    wd_state == SOV_WD_FIRED && !rst_ctl[7] && wd_cfg[7] && !kick_edge
    |=> !watchdog_expiry_out_b)
    else $error("watchdog released without kick edge");
  wd_expire_a: assert property (
    wd_state == SOV_WD_STEADY && wd_cnt == 25'd0 && !kick_edge && reset_out_b
    && wd_cfg[7] |=> !watchdog_expiry_out_b)
    else $error("watchdog did not expire");
  wd_first_a: assert property (
    $rose(wd_cfg[7]) |=> wd_state == SOV_WD_FIRST)
    else $error("initial period not started on enable");

  rst_release_c: cover property ($rose(reset_out_b));
  wd_expire_c: cover property ($fell(watchdog_expiry_out_b));
  wd_kick_c: cover property (wd_state == SOV_WD_STEADY && kick_edge);
endmodule : sov_top
`default_nettype wire

//--- testbench/sov_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module sov_cpu #(
  parameter int GAP = 1000
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic reset_out_b,
  input  wire logic kick_en,
  output logic      kick
);
  int cnt;
  initial kick = 1'b0;
  // Toggle at once when enabled, then every GAP cycles; silent while held in reset
  // kick each period
  always @(negedge clk) begin
    if (!rst_b || !kick_en || !reset_out_b) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        kick <= ~kick;
      end
    end
  end
endmodule : sov_cpu
`default_nettype wire

//--- testbench/sov_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sov_map.svh"
module sov_top_tb
  import sov_pkg::*;
;
  localparam int TC = 2;
  logic       clk, rst_b, cfg_wr, mr_b, kick, ken, rout_b, fout_b, wout_b, rod, fod, wod;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [5:0] pok, sok;
  int         err_count, checks, cyc, n;

  sov_top #(.TICK_CYC(TC)) dut (.clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .manual_reset_in_b(mr_b), .monitored_supply_prim_ok(pok),
    .monitored_supply_sec_ok(sok), .watchdog_kick_in(kick), .reset_out_b(rout_b),
    .voltage_fault_flag_out_b(fout_b), .watchdog_expiry_out_b(wout_b),
    .reset_open_drain(rod), .flag_open_drain(fod), .wd_open_drain(wod));
  sov_cpu cpu (.clk(clk), .rst_b(rst_b), .reset_out_b(rout_b), .kick_en(ken), .kick(kick));

  // Free-running clock and a hang guard well above the expected run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      close_out();
    end
  end

  function automatic logic sig(input int s);
    return (s == 0) ? rout_b : (s == 1) ? fout_b : wout_b;
  endfunction : sig

  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask : chk8

  task automatic chk1(input string s, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s exp %b got %b", s, e, g);
    end
  endtask : chk1

  task automatic rng(input string s, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("Error %s exp %0d..%0d got %0d", s, lo, hi, n);
    end
  endtask : rng

  // Bus cycles change only at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    cfg_addr = a;
    @(negedge clk);
    chk8("rdata", e, cfg_rdata);
  endtask : rd

  // Bounded wait; n holds the cycles spent
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (n < lim && sig(s) !== v) begin
      @(negedge clk);
      n++;
    end
  endtask : wt

  task automatic drv(input int s, input logic [5:0] v);
    if (s == 0) pok = v;
    else sok = v;
  endtask : drv

  task automatic t_regs();
    rd(8'h11, 8'h01);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h01);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h17, 8'h17);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h8F);
    chk1("rst_mode", 1'b1, rod);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h0F);
    chk1("flg_mode", 1'b1, fod);
    wr(8'h16, 8'h55);
    rd(8'h16, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h14, 8'h00);
    chk1("rst_mode", 1'b0, rod);
  endtask : t_regs

  // Release delay for codes 0 and 1, counted from the clearing edge
  task automatic t_rel(input int s, input logic [7:0] a);
    int us [2];
    int tk;
    us = '{`SOV_T_R0_US, `SOV_T_R1_US};
    for (int c = 0; c < 2; c++) begin
      tk = us[c] / `SOV_TICK_US;
      wr(a, 8'(c << 1));
      mr_b = 1'b0;
      wt(s, 1'b0, 3);
      chk1("assert", 1'b0, sig(s));
      repeat (3) @(negedge clk);
      mr_b = 1'b1;
      wt(s, 1'b1, (tk + 2) * TC + 10);
      rng("delay", tk * TC, (tk + 1) * TC + 4);
    end
    wr(a, 8'h00);
  endtask : t_rel

  // Each supply bit, enabled alone, trips its output even with the neighbour also low; a low neighbour that is not enabled does not
  task automatic t_src(input int s, input logic [7:0] a);
    int j;
    for (int i = 0; i < 6; i++) begin
      j = (i + 1) % 6;
      wr(a, 8'h04 << i);
      drv(s, ~(6'h01 << j));
      repeat (4) @(negedge clk);
      chk1("idle", 1'b1, sig(s));
      drv(s, ~((6'h01 << j) | (6'h01 << i)));
      wt(s, 1'b0, 3);
      chk1("trip", 1'b0, sig(s));
      drv(s, 6'h3F);
      wt(s, 1'b1, 20);
      chk1("free", 1'b1, sig(s));
    end
    wr(a, 8'h01);
  endtask : t_src

  task automatic t_peer();
    wr(8'h13, 8'h02);
    mr_b = 1'b0;
    wt(1, 1'b0, 4);
    chk1("peer", 1'b0, fout_b);
    mr_b = 1'b1;
    wt(1, 1'b1, 40);
    chk1("peer", 1'b1, fout_b);
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h00);
    repeat (30) @(negedge clk);
    chk1("empty", 1'b0, fout_b);
    chk1("peer", 1'b0, rout_b);
    wr(8'h13, 8'h01);
    wt(0, 1'b1, 60);
    chk1("peer", 1'b1, rout_b);
    wr(8'h11, 8'h01);
  endtask : t_peer

  task automatic t_wd();
    repeat (5200) @(negedge clk);
    chk1("wd_off", 1'b1, wout_b);
    wr(8'h15, 8'hD1);
    rd(8'h15, 8'hD1);
    chk1("wd_mode", 1'b1, wod);
    ken <= 1'b1;
    n = 0;
    repeat (8000) begin
      @(negedge clk);
      if (wout_b !== 1'b1) n++;
    end
    rng("kicked", 0, 0);
    ken <= 1'b0;
    wt(2, 1'b0, 3000);
    rng("expiry", 1500, 2570);
    repeat (200) @(negedge clk);
    chk1("held", 1'b0, wout_b);
    chk1("no_dep", 1'b1, rout_b);
    ken <= 1'b1;
    @(negedge clk);
    ken <= 1'b0;
    wt(2, 1'b1, 6);
    chk1("kick_clr", 1'b1, wout_b);
    wr(8'h12, 8'h80);
    wt(2, 1'b0, 5600);
    rng("first", 5040, 5080);
    wt(2, 1'b1, 300);
    rng("pulse", 5, 5);
    chk1("wd_rst", 1'b0, rout_b);
    wt(0, 1'b1, 40);
    chk1("wd_rst", 1'b1, rout_b);
    wr(8'h12, 8'h00);
    wr(8'h15, 8'h00);
  endtask : t_wd

  task automatic close_out();
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Main sequence: reset for 12 cycles, then each scenario in turn
  initial begin
    {rst_b, cfg_wr, ken} = 3'b000;
    {cfg_addr, cfg_wdata} = 16'h0000;
    {mr_b, pok, sok} = 13'h1FFF;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    wt(0, 1'b1, 40);
    chk1("boot", 1'b1, rout_b);
    t_regs();
    t_rel(0, 8'h12);
    t_rel(1, 8'h14);
    t_src(0, 8'h11);
    t_src(1, 8'h13);
    t_peer();
    t_wd();
    close_out();
  end
endmodule : sov_top_tb
`default_nettype wire
